/* design/fsws_consts.vh */
// constants for the flash write-status polling controller
`ifndef FSWS_CONSTS_VH
`define FSWS_CONSTS_VH

// register byte offsets
`define FSWS_REG_CTRL    8'h00
`define FSWS_REG_ADDR    8'h04
`define FSWS_REG_EXP     8'h08
`define FSWS_REG_STATUS  8'h0c
`define FSWS_REG_RDATA   8'h10
`define FSWS_REG_POLLS   8'h14

// control register fields
`define FSWS_CTRL_START  0
`define FSWS_CTRL_TOGGLE 1
`define FSWS_CTRL_ABORT  2

// status register fields
`define FSWS_ST_BUSY     0
`define FSWS_ST_PASS     1
`define FSWS_ST_FAIL     2
`define FSWS_ST_READY    3

// flash data bus bit positions
`define FSWS_BIT_POLL    7
`define FSWS_BIT_TOG1    6
`define FSWS_BIT_TMO     5
`define FSWS_BIT_TOG2    2

// widths and reset values
`define FSWS_AW          22
`define FSWS_DW          16
`define FSWS_RESET_CMD   16'h00f0

// strobe phase: 100 ns at 25 ns clock period
`define FSWS_PHASE_NS    100
`define FSWS_CLK_NS      25
`define FSWS_PHASE_CYC   ((`FSWS_PHASE_NS + `FSWS_CLK_NS - 1) / `FSWS_CLK_NS)

`endif

/* design/fsws_cycle.v */
// one asynchronous flash bus cycle (read or write) on the flash pins
`timescale 1ns/1ps
`include "fsws_consts.vh"

module fsws_cycle (
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 start,
  input  wire                 wr,
  input  wire [`FSWS_AW-1:0]  addr,
  input  wire [`FSWS_DW-1:0]  wdata,
  input  wire [`FSWS_DW-1:0]  flash_dq_i,
  output reg                  done_r,
  output reg  [`FSWS_DW-1:0]  rdata_r,
  output reg  [`FSWS_AW-1:0]  flash_addr_r,
  output reg  [`FSWS_DW-1:0]  flash_dq_o_r,
  output reg                  flash_dq_oe_r,
  output reg                  flash_ce_n_r,
  output reg                  flash_oe_n_r,
  output reg                  flash_we_n_r
);

  localparam [1:0] C_IDLE  = 2'd0;
  localparam [1:0] C_SETUP = 2'd1;
  localparam [1:0] C_STRB  = 2'd2;
  localparam [1:0] C_HOLD  = 2'd3;
  localparam integer PH_CYC  = `FSWS_PHASE_CYC - 1;
  localparam [3:0]   PH_LAST = PH_CYC[3:0];

  reg [1:0]          st_r;
  reg [3:0]          cnt_r;
  reg                wr_r;
  reg [`FSWS_DW-1:0] dq_s1_r;
  reg [`FSWS_DW-1:0] dq_s2_r;

  // *****************************
  // pin synchroniser
  // *****************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
    end else begin
      dq_s1_r <= flash_dq_i;
      dq_s2_r <= dq_s1_r;
    end
  end

  // *****************************
  // cycle sequencer
  // *****************************
  // data is taken two edges after the strobe phase so the
  // synchroniser has settled before the strobe rises
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= C_IDLE;
      cnt_r         <= 4'h0;
      wr_r          <= 1'b0;
      done_r        <= 1'b0;
      rdata_r       <= 16'h0000;
      flash_addr_r  <= 22'h000000;
      flash_dq_o_r  <= 16'h0000;
      flash_dq_oe_r <= 1'b0;
      flash_ce_n_r  <= 1'b1;
      flash_oe_n_r  <= 1'b1;
      flash_we_n_r  <= 1'b1;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        C_IDLE: begin
          if (start) begin
            wr_r          <= wr;
            flash_addr_r  <= addr;
            flash_dq_o_r  <= wdata;
            flash_dq_oe_r <= wr;
            flash_ce_n_r  <= 1'b0;
            cnt_r         <= 4'h0;
            st_r          <= C_SETUP;
          end
        end
        C_SETUP: begin
          flash_oe_n_r <= wr_r;
          flash_we_n_r <= ~wr_r;
          cnt_r        <= 4'h0;
          st_r         <= C_STRB;
        end
        C_STRB: begin
          if (cnt_r == PH_LAST + 4'd2) begin
            if (!wr_r)
              rdata_r <= dq_s2_r;
            flash_oe_n_r <= 1'b1;
            flash_we_n_r <= 1'b1;
            st_r         <= C_HOLD;
          end else begin
            cnt_r <= cnt_r + 4'd1;
          end
        end
        C_HOLD: begin
          // ce rises after the strobe so each read is a distinct cycle
          flash_ce_n_r  <= 1'b1;
          flash_dq_oe_r <= 1'b0;
          done_r        <= 1'b1;
          st_r          <= C_IDLE;
        end
        default: st_r <= C_IDLE;
      endcase
    end
  end

endmodule

/* design/fsws_host.v */
// host controller that polls flash write-operation status over its pins
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`include "fsws_consts.vh"

module fsws_host (
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [7:0]           paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata_r,
  output reg                  pready_r,
  output reg                  pslverr_r,
  output wire [`FSWS_AW-1:0]  flash_addr,
  output wire [`FSWS_DW-1:0]  flash_dq_o,
  output wire                 flash_dq_oe,
  input  wire [`FSWS_DW-1:0]  flash_dq_i,
  output wire                 flash_ce_n,
  output wire                 flash_oe_n,
  output wire                 flash_we_n,
  input  wire                 ready_busy_n
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_RDA  = 3'd1;
  localparam [2:0] S_WA   = 3'd2;
  localparam [2:0] S_RDB  = 3'd3;
  localparam [2:0] S_WB   = 3'd4;
  localparam [2:0] S_RST  = 3'd5;
  localparam [2:0] S_WRST = 3'd6;

  reg [2:0]          st_r;
  reg [`FSWS_AW-1:0] addr_r;
  reg [`FSWS_DW-1:0] exp_r;
  reg                tog_mode_r;
  reg                recheck_r;
  reg                pass_r;
  reg                fail_r;
  reg [`FSWS_DW-1:0] first_r;
  reg [31:0]         polls_r;
  reg                rb_s1_r;
  reg                rb_s2_r;
  reg                cyc_start_r;
  reg                cyc_wr_r;

  wire               cyc_done;
  wire [`FSWS_DW-1:0] cyc_rdata;
  wire               busy;
  wire               wr_acc;
  wire               toggled;
  wire               poll_match;

  assign busy       = (st_r != S_IDLE);
  assign wr_acc     = psel & penable & pready_r & pwrite;
  // both toggle bits are compared so erase-suspended sectors also show
  assign toggled    = (first_r[`FSWS_BIT_TOG1] ^ cyc_rdata[`FSWS_BIT_TOG1]) |
                      (first_r[`FSWS_BIT_TOG2] ^ cyc_rdata[`FSWS_BIT_TOG2]);
  assign poll_match = (cyc_rdata[`FSWS_BIT_POLL] == exp_r[`FSWS_BIT_POLL]);

  fsws_cycle u_cyc (
    .pclk          (pclk),
    .presetn       (presetn),
    .start         (cyc_start_r),
    .wr            (cyc_wr_r),
    .addr          (addr_r),
    .wdata         (`FSWS_RESET_CMD),
    .flash_dq_i    (flash_dq_i),
    .done_r        (cyc_done),
    .rdata_r       (cyc_rdata),
    .flash_addr_r  (flash_addr),
    .flash_dq_o_r  (flash_dq_o),
    .flash_dq_oe_r (flash_dq_oe),
    .flash_ce_n_r  (flash_ce_n),
    .flash_oe_n_r  (flash_oe_n),
    .flash_we_n_r  (flash_we_n)
  );

  // *****************************
  // ready/busy synchroniser
  // *****************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_s1_r <= 1'b1;
      rb_s2_r <= 1'b1;
    end else begin
      rb_s1_r <= ready_busy_n;
      rb_s2_r <= rb_s1_r;
    end
  end

  // *****************************
  // apb slave
  // *****************************
  // one wait-free access cycle: pready rises in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
      addr_r    <= 22'h000000;
      exp_r     <= 16'h0000;
    end else begin
      pready_r  <= psel & ~penable;
      pslverr_r <= psel & ~penable & (paddr > `FSWS_REG_POLLS |
                   paddr[1:0] != 2'b00);
      if (psel & ~penable) begin
        case (paddr)
          `FSWS_REG_CTRL:   prdata_r <= {31'h0, tog_mode_r};
          `FSWS_REG_ADDR:   prdata_r <= {10'h000, addr_r};
          `FSWS_REG_EXP:    prdata_r <= {16'h0000, exp_r};
          `FSWS_REG_STATUS: prdata_r <= {28'h0000000, rb_s2_r, fail_r,
                                         pass_r, busy};
          `FSWS_REG_RDATA:  prdata_r <= {16'h0000, cyc_rdata};
          `FSWS_REG_POLLS:  prdata_r <= polls_r;
          default:          prdata_r <= 32'h00000000;
        endcase
      end
      // address is held while a poll runs so status stays valid
      if (wr_acc && !busy && paddr == `FSWS_REG_ADDR)
        addr_r <= pwdata[`FSWS_AW-1:0];
      if (wr_acc && !busy && paddr == `FSWS_REG_EXP)
        exp_r <= pwdata[`FSWS_DW-1:0];
    end
  end

  // *****************************
  // polling sequencer
  // *****************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= S_IDLE;
      tog_mode_r  <= 1'b0;
      recheck_r   <= 1'b0;
      pass_r      <= 1'b0;
      fail_r      <= 1'b0;
      first_r     <= 16'h0000;
      polls_r     <= 32'h00000000;
      cyc_start_r <= 1'b0;
      cyc_wr_r    <= 1'b0;
    end else begin
      cyc_start_r <= 1'b0;
      if (wr_acc && paddr == `FSWS_REG_CTRL &&
          pwdata[`FSWS_CTRL_ABORT]) begin
        // abandoned poll must start over from the top later
        st_r      <= S_IDLE;
        recheck_r <= 1'b0;
      end else begin
        case (st_r)
          S_IDLE: begin
            if (wr_acc && paddr == `FSWS_REG_CTRL &&
                pwdata[`FSWS_CTRL_START]) begin
              tog_mode_r <= pwdata[`FSWS_CTRL_TOGGLE];
              recheck_r  <= 1'b0;
              pass_r     <= 1'b0;
              fail_r     <= 1'b0;
              polls_r    <= 32'h00000000;
              st_r       <= S_RDA;
            end
          end
          S_RDA: begin
            cyc_wr_r    <= 1'b0;
            cyc_start_r <= 1'b1;
            polls_r     <= polls_r + 32'h1;
            st_r        <= S_WA;
          end
          S_WA: begin
            if (cyc_done) begin
              first_r <= cyc_rdata;
              if (tog_mode_r) begin
                st_r <= S_RDB;
              end else if (poll_match) begin
                // early flip of bit 7 alone; array data only on later reads
                pass_r <= 1'b1;
                st_r   <= S_IDLE;
              end else if (recheck_r) begin
                fail_r <= 1'b1;
                st_r   <= S_RST;
              end else begin
                recheck_r <= cyc_rdata[`FSWS_BIT_TMO];
                st_r      <= S_RDA;
              end
            end
          end
          S_RDB: begin
            cyc_wr_r    <= 1'b0;
            cyc_start_r <= 1'b1;
            st_r        <= S_WB;
          end
          S_WB: begin
            if (cyc_done) begin
              if (!toggled) begin
                pass_r <= 1'b1;
                st_r   <= S_IDLE;
              end else if (recheck_r) begin
                fail_r <= 1'b1;
                st_r   <= S_RST;
              end else begin
                recheck_r <= cyc_rdata[`FSWS_BIT_TMO];
                st_r      <= S_RDA;
              end
            end
          end
          S_RST: begin
            cyc_wr_r    <= 1'b1;
            cyc_start_r <= 1'b1;
            st_r        <= S_WRST;
          end
          S_WRST: begin
            if (cyc_done)
              st_r <= S_IDLE;
          end
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end

endmodule

/* verif/fsws_monitor.sv */
// assertion checker for the flash status polling host
`timescale 1ns/1ps
`include "fsws_consts.vh"
module fsws_monitor (
  input wire                pclk,
  input wire                presetn,
  input wire                psel,
  input wire                penable,
  input wire [7:0]          paddr,
  input wire                pready_r,
  input wire                pslverr_r,
  input wire [`FSWS_AW-1:0] flash_addr,
  input wire [`FSWS_DW-1:0] flash_dq_o,
  input wire                flash_dq_oe,
  input wire                flash_ce_n,
  input wire                flash_oe_n,
  input wire                flash_we_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence rd_open_s;
    $fell(flash_oe_n) && !flash_ce_n;
  endsequence
  sequence wr_open_s;
    $fell(flash_we_n);
  endsequence
  // strobe must cover the whole phase, then end
  sequence strobe_s(sig);
    !sig [*4] ##[1:16] sig;
  endsequence
  apb_answer_a: assert property (setup_s |=> pready_r)
    else $error("apb access not answered at once");
  ready_pulse_a: assert property (pready_r |=> !pready_r)
    else $error("pready held too long");
  bad_addr_a: assert property (pready_r && paddr > 8'h14 |-> pslverr_r)
    else $error("unmapped access not flagged");
  read_hold_a: assert property (
    rd_open_s |-> strobe_s(flash_oe_n))
    else $error("read strobe wrong length");
  read_float_a: assert property (
    !flash_oe_n |-> !flash_dq_oe && !flash_ce_n)
    else $error("read strobe without select or with drive");
  addr_hold_a: assert property (
    !flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
    else $error("flash address moved in a cycle");
  reset_cmd_a: assert property (
    wr_open_s |-> flash_dq_oe && !flash_ce_n
      && flash_dq_o == `FSWS_RESET_CMD)
    else $error("write is not the reset command");
  write_pulse_a: assert property (
    wr_open_s |-> strobe_s(flash_we_n))
    else $error("write strobe wrong length");
  ce_gap_a: assert property ($rose(flash_ce_n) |=> flash_ce_n)
    else $error("no idle cycle between flash cycles");
  strobe_excl_a: assert property (!(!flash_oe_n && !flash_we_n))
    else $error("read and write strobes together");
endmodule

bind fsws_host fsws_monitor mon (
  .pclk, .presetn, .psel, .penable, .paddr, .pready_r, .pslverr_r,
  .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_ce_n, .flash_oe_n,
  .flash_we_n
);

/* verif/fsws_flash_model.sv */
// behavioural flash device answering status reads on its pins
`timescale 1ns/1ps
module fsws_flash_model (
  input  wire        go,
  input  wire [7:0]  busy_reads,
  input  wire        erase,
  input  wire        hang,
  input  wire        flash_dq_oe,
  input  wire [15:0] flash_dq_o,
  input  wire        flash_ce_n,
  input  wire        flash_oe_n,
  input  wire        flash_we_n,
  output wire [15:0] dq,
  output wire        ready_busy_n
);
  logic [7:0]  left = 8'h00;
  logic        busy = 1'b0;
  logic        tog = 1'b0;
  logic        tmo = 1'b0;
  logic [15:0] last = 16'h0000;
  wire  [15:0] dat = erase ? 16'hffff : 16'h5aa5;
  // other bits stay junk while busy, as the real part allows
  wire  [15:0] st = {~dat[15:8], erase ? 1'b0 : ~dat[7], tog, tmo,
    ~dat[4:3], erase & tog, ~dat[1:0]};
  wire  [15:0] val = busy ? st : dat;
  // released bus shows no stale value
  assign dq = (!flash_ce_n && !flash_oe_n) ? val : ~last;
  assign ready_busy_n = !busy;
  // busy window is a count of status reads
  always @(posedge go) begin
    busy = 1'b1;
    left = busy_reads;
    tog = 1'b0;
    tmo = 1'b0;
  end
  always @(posedge flash_oe_n) begin
    if (!flash_ce_n) begin
      last = val;
      if (busy) begin
        tog = ~tog;
        if (left > 8'h01) left = left - 8'h01;
        else if (hang) tmo = 1'b1;
        else busy = 1'b0;
      end
    end
  end
  always @(posedge flash_we_n) begin
    if (!flash_ce_n && flash_dq_oe && flash_dq_o[7:0] == 8'hf0) begin
      busy = 1'b0;
      tmo = 1'b0;
    end
  end
endmodule

/* verif/tb_top.sv */
// self-checking bench for the flash status polling host
`timescale 1ns/1ps
`include "fsws_consts.vh"
module tb_top;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic                go = 1'b0;
  logic                erase = 1'b0;
  logic                hang = 1'b0;
  logic [7:0]          busy_reads = 8'h03;
  wire  [31:0]         prdata_r;
  wire                 pready_r, pslverr_r, flash_dq_oe;
  wire  [`FSWS_AW-1:0] flash_addr;
  wire  [`FSWS_DW-1:0] flash_dq_o, flash_dq_i;
  wire                 flash_ce_n, flash_oe_n, flash_we_n;
  wire                 ready_busy_n;
  logic [31:0]         q;
  logic                err;
  int                  n_errors = 0;
  int                  cmp_count = 0;
  int                  cyc = 0;
  int                  n_rst = 0;

  fsws_host dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata_r, .pready_r, .pslverr_r, .flash_addr, .flash_dq_o,
    .flash_dq_oe, .flash_dq_i, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .ready_busy_n);
  fsws_flash_model flash (.go, .busy_reads, .erase, .hang, .flash_dq_oe,
    .flash_dq_o, .flash_ce_n, .flash_oe_n, .flash_we_n, .dq(flash_dq_i),
    .ready_busy_n);

  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // only the reset command is ever written
  always @(posedge flash_we_n) n_rst++;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      final_report;
    end
  end

  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the bench timeout ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready_r !== 1'b1);
    q = prdata_r;
    err = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, `FSWS_REG_STATUS, 32'h0);
      k++;
    end while (q[`FSWS_ST_BUSY] !== 1'b0 && k < 400);
  endtask

  task t_regs;
    apb(1'b0, `FSWS_REG_STATUS, 32'h0);
    chk("status_idle", q, 32'h8);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_data", q, 32'h0);
    apb(1'b0, 8'h06, 32'h0);
    chk("unaligned_err", err, 1'b1);
  endtask
  task t_op(input logic tm, input logic er, input logic hg);
    int          r0;
    logic [15:0] dat;
    dat = er ? 16'hffff : 16'h5aa5;
    r0 = n_rst;
    erase <= er;
    hang <= hg;
    busy_reads <= 8'h03;
    go <= 1'b1;
    apb(1'b1, `FSWS_REG_ADDR, 32'h1234);
    go <= 1'b0;
    apb(1'b1, `FSWS_REG_EXP, {16'h0, dat});
    apb(1'b0, `FSWS_REG_STATUS, 32'h0);
    chk("busy_pin", q[`FSWS_ST_READY], 1'b0);
    apb(1'b1, `FSWS_REG_CTRL, {30'h0, tm, 1'b1});
    // address reaches the pins only when the first read opens
    wait (flash_ce_n === 1'b0);
    chk("poll_addr", {10'h0, flash_addr}, 32'h1234);
    wait_idle;
    chk("verdict", q[2:0], hg ? 3'b100 : 3'b010);
    chk("reset_cmds", n_rst - r0, hg);
    if (!hg) begin
      apb(1'b0, `FSWS_REG_RDATA, 32'h0);
      chk("array_data", q, {16'h0, dat});
      if (!tm) begin
        apb(1'b0, `FSWS_REG_POLLS, 32'h0);
        chk("poll_reads", q, 32'h4);
      end
    end
    apb(1'b0, `FSWS_REG_STATUS, 32'h0);
    chk("ready_after", q[`FSWS_ST_READY], 1'b1);
  endtask
  task t_abort;
    hang <= 1'b0;
    busy_reads <= 8'hff;
    go <= 1'b1;
    apb(1'b1, `FSWS_REG_CTRL, 32'h3);
    go <= 1'b0;
    apb(1'b0, `FSWS_REG_CTRL, 32'h0);
    chk("ctrl_mode", q, 32'h1);
    apb(1'b1, `FSWS_REG_ADDR, 32'h777);
    apb(1'b0, `FSWS_REG_ADDR, 32'h0);
    chk("addr_locked", q, 32'h1234);
    apb(1'b1, `FSWS_REG_CTRL, 32'h4);
    wait_idle;
    chk("aborted", q[`FSWS_ST_BUSY], 1'b0);
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    for (int m = 0; m < 8; m++) t_op(m[2], m[1], m[0]);
    t_abort;
    final_report;
  end
endmodule
